// file: core/acr_cfg_reg.sv
// one 8-bit configuration register with per-bit write mask
// assumes writes arrive as single-cycle enables on clk_in
`timescale 1ns/10ps

module acr_cfg_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK = 8'hff
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] value_out
);
	logic [7:0] value_r;
	logic [7:0] value_nxt;

	////////////////////////////////////////////////////////////////////////
	// masked bits keep their reset value, so read-only bits stay at RESET_VAL
	always_comb begin
		value_nxt = value_r;
		if (wr_en_in) begin
			value_nxt = (wdata_in & WMASK) | (RESET_VAL & ~WMASK);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			value_r <= RESET_VAL;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign value_out = value_r;

endmodule // acr_cfg_reg

// file: core/acr_level_map.sv
// maps volume and trim codes to signed level steps, registered
// assumes codes come from registers on the same clock
`timescale 1ns/10ps

module acr_level_map (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] volume_code_in,
	input wire logic [3:0] trim_code_in,
	output logic mute_out,
	output logic [8:0] volume_half_db_out,
	output logic [4:0] trim_tenth_db_out
);
	import acr_pkg::*;

	logic mute_r;
	logic [8:0] volume_half_db_r;
	logic [4:0] trim_tenth_db_r;

	////////////////////////////////////////////////////////////////////////
	// mute overrides the level; level is held at zero while muted
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mute_r <= 1'b0;
			volume_half_db_r <= 9'h000;
		end else begin
			mute_r <= (volume_code_in == ACR_VOL_MUTE);
			if (volume_code_in == ACR_VOL_MUTE) begin
				volume_half_db_r <= 9'h000;
			end else begin
				// two's complement, half-dB units, 0 at code 201
				volume_half_db_r <= {1'b0, volume_code_in} - ACR_VOL_ZERO_DB;
			end
		end
	end

	// trim in tenths of a dB, 0 at code 8
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			trim_tenth_db_r <= 5'h00;
		end else begin
			trim_tenth_db_r <= {1'b0, trim_code_in} - ACR_TRIM_ZERO_DB;
		end
	end

	assign mute_out = mute_r;
	assign volume_half_db_out = volume_half_db_r;
	assign trim_tenth_db_out = trim_tenth_db_r;

endmodule // acr_level_map

// file: core/acr_regs.sv
// channel 3 configuration bank: apb slave, four setup registers,
// status register and registered settings toward the analog channel
// assumes apb master and agc setup bit on clk_in; no pin inputs
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps

module acr_regs (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire acr_pkg::acr_apb_req_type apb_req_in,
	input wire logic agc_setup_mode_in,
	output acr_pkg::acr_apb_rsp_type apb_rsp_out,
	output acr_pkg::acr_setup_type setup_out,
	output logic agc_run_out,
	output logic channel_mute_out,
	output logic [8:0] volume_half_db_out,
	output logic [4:0] trim_tenth_db_out
);
	import acr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// bus state
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic access_phase;
	logic xfer_done;
	logic wr_strobe;
	logic hit_setup;
	logic hit_gain;
	logic hit_volume;
	logic hit_trim;
	logic hit_status;
	logic hit_any;

	// register contents
	logic [7:0] setup_q;
	logic [7:0] gain_q;
	logic [7:0] volume_q;
	logic [7:0] trim_q;
	logic [7:0] status_q;
	logic [7:0] rd_mux;

	// derived state
	logic retune_r;
	logic retune_nxt;
	logic agc_run_r;
	acr_setup_type setup_r;
	acr_setup_type setup_nxt;
	logic level_mute;
	logic [8:0] level_vol;
	logic [4:0] level_trim;

	////////////////////////////////////////////////////////////////////////
	// address decode; misaligned or unknown addresses hit nothing
	always_comb begin
		hit_setup = (apb_req_in.paddr == acr_byte_addr(ACR_IDX_INPUT_SETUP));
		hit_gain = (apb_req_in.paddr == acr_byte_addr(ACR_IDX_GAIN));
		hit_volume = (apb_req_in.paddr == acr_byte_addr(ACR_IDX_VOLUME));
		hit_trim = (apb_req_in.paddr == acr_byte_addr(ACR_IDX_TRIM));
		hit_status = (apb_req_in.paddr == acr_byte_addr(ACR_IDX_STATUS));
		hit_any = hit_setup | hit_gain | hit_volume | hit_trim | hit_status;
	end

	// one wait state: pready rises in the second access cycle, and the
	// transfer completes at the edge that samples it high
	assign access_phase = apb_req_in.psel & apb_req_in.penable;
	assign xfer_done = access_phase & pready_r;
	assign wr_strobe = xfer_done & apb_req_in.pwrite;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= access_phase & ~pready_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the four channel registers; read-only bits held by their masks
	acr_cfg_reg #(
		.RESET_VAL(ACR_RST_INPUT_SETUP),
		.WMASK(ACR_WMASK_INPUT_SETUP)
	) u_setup_reg (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(wr_strobe & hit_setup),
		.wdata_in(apb_req_in.pwdata[7:0]),
		.value_out(setup_q)
	);

	// bit 1 stored as written, bit 0 always zero
	acr_cfg_reg #(
		.RESET_VAL(ACR_RST_GAIN),
		.WMASK(ACR_WMASK_GAIN)
	) u_gain_reg (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(wr_strobe & hit_gain),
		.wdata_in(apb_req_in.pwdata[7:0]),
		.value_out(gain_q)
	);

	acr_cfg_reg #(
		.RESET_VAL(ACR_RST_VOLUME),
		.WMASK(ACR_WMASK_VOLUME)
	) u_volume_reg (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(wr_strobe & hit_volume),
		.wdata_in(apb_req_in.pwdata[7:0]),
		.value_out(volume_q)
	);

	// low nibble reserved and read-only
	acr_cfg_reg #(
		.RESET_VAL(ACR_RST_TRIM),
		.WMASK(ACR_WMASK_TRIM)
	) u_trim_reg (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(wr_strobe & hit_trim),
		.wdata_in(apb_req_in.pwdata[7:0]),
		.value_out(trim_q)
	);

	////////////////////////////////////////////////////////////////////////
	// field split of the stored registers
	always_comb begin
		setup_nxt.input_kind_select = setup_q[ACR_POS_KIND];
		setup_nxt.input_source_select =
			setup_q[ACR_POS_SRC_HI:ACR_POS_SRC_LO];
		setup_nxt.coupling_select = setup_q[ACR_POS_COUPLING];
		setup_nxt.mic_swing_range = setup_q[ACR_POS_SWING];
		setup_nxt.amplifier_perf_mode =
			setup_q[ACR_POS_PERF_HI:ACR_POS_PERF_LO];
		setup_nxt.auto_gain_enable = setup_q[ACR_POS_AGC];
		setup_nxt.analog_gain_code =
			gain_q[ACR_POS_GAIN_HI:ACR_POS_GAIN_LO];
		setup_nxt.digital_volume_code = volume_q;
		setup_nxt.gain_trim_code =
			trim_q[ACR_POS_TRIM_HI:ACR_POS_TRIM_LO];
	end

	// settings toward the channel come from flip-flops; they lag the
	// register contents by one cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			setup_r <= '0;
		end else begin
			setup_r <= setup_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// agc runs only when enabled here and qualified by the agc setup bit
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			agc_run_r <= 1'b0;
		end else begin
			agc_run_r <= setup_nxt.auto_gain_enable & agc_setup_mode_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level steps for the digital path
	acr_level_map u_level_map (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.volume_code_in(volume_q),
		.trim_code_in(setup_nxt.gain_trim_code),
		.mute_out(level_mute),
		.volume_half_db_out(level_vol),
		.trim_tenth_db_out(level_trim)
	);

	////////////////////////////////////////////////////////////////////////
	// retune flag: set when high swing is written, cleared by the next
	// write to gain or volume; a new high-swing write wins over a clear
	always_comb begin
		retune_nxt = retune_r;
		if (wr_strobe & (hit_gain | hit_volume)) begin
			retune_nxt = 1'b0;
		end
		if (wr_strobe & hit_setup & apb_req_in.pwdata[ACR_POS_SWING]) begin
			retune_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			retune_r <= 1'b0;
		end else begin
			retune_r <= retune_nxt;
		end
	end

	// live status; codes the channel cannot honour are flagged, not fixed
	always_comb begin
		status_q = 8'h00;
		status_q[ACR_ST_SRC_RSVD] =
			setup_nxt.input_source_select[1];
		status_q[ACR_ST_PERF_BAD] =
			(setup_nxt.amplifier_perf_mode != ACR_PERF_SNR) &&
			(setup_nxt.amplifier_perf_mode != ACR_PERF_CMRR);
		status_q[ACR_ST_GAIN_RSVD] =
			(setup_nxt.analog_gain_code > ACR_GAIN_MAX);
		status_q[ACR_ST_AGC_ON_DC] = setup_nxt.auto_gain_enable &
			setup_nxt.coupling_select;
		status_q[ACR_ST_RETUNE] = retune_r;
		status_q[ACR_ST_MUTED] = level_mute;
	end

	////////////////////////////////////////////////////////////////////////
	// read data; bits above the 8-bit register read as zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (1'b1)
			hit_setup: begin
				rd_mux = setup_q;
			end
			hit_gain: begin
				rd_mux = gain_q;
			end
			hit_volume: begin
				rd_mux = volume_q;
			end
			hit_trim: begin
				rd_mux = trim_q;
			end
			hit_status: begin
				rd_mux = status_q;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// read data and error are loaded as pready rises and held after
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (access_phase & ~pready_r) begin
			prdata_r <= apb_req_in.pwrite ? 32'h0000_0000 :
				{24'h00_0000, rd_mux};
			pslverr_r <= ~hit_any;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops
	assign apb_rsp_out.pready = pready_r;
	assign apb_rsp_out.pslverr = pslverr_r;
	assign apb_rsp_out.prdata = prdata_r;
	assign setup_out = setup_r;
	assign agc_run_out = agc_run_r;
	assign channel_mute_out = level_mute;
	assign volume_half_db_out = level_vol;
	assign trim_tenth_db_out = level_trim;

endmodule // acr_regs

// file: inc/acr_pkg.sv
// constants, field layouts and carrier types for the channel 3 config bank
// assumes one 125 MHz clock, synchronous active-high reset, apb access
//
// Contract
// - bit 7 of the input setup register picks microphone (0) or line (1) input and resets to 0.
// - bits 6-5 of the input setup register pick differential (0) or single-ended (1) source, 2 and 3 reserved, reset 00b.
// - bit 4 of the input setup register picks ac (0) or dc (1) coupling and resets to 1.
// - bit 3 of the input setup register picks low (0) or high (1) mic swing, resets to 0, and high swing asks software to redo gain and volume.
// - bits 2-1 of the input setup register pick high snr (0) or high cmrr (2), code 1 is forbidden, code 3 reserved, reset 00b.
// - bit 0 of the input setup register enables agc as steered by bit 3 of the agc setup register, meant only for ac coupling, reset 0.
// - bits 7-2 of the gain register give analog gain 0 to 42 dB in 1 dB steps, codes 43 to 63 reserved, reset 0.
// - a digital volume code of zero mutes the channel.
// - digital volume runs in 0.5 dB steps with code 1 at -100 dB, 201 at 0 dB and 255 at 27 dB.
// - the digital volume field is bits 7-0 of its register and resets to 11001001b.
// - the gain register sits at 0x47 and resets to 0x0.
// - the digital volume register sits at 0x48 and resets to 0xc9.
// - the gain trim register sits at 0x49 and resets to 0x80.
// - bits 7-4 of the trim register trim gain in 0.1 dB steps, code 8 is 0 dB, bits 3-0 read-only.

package acr_pkg;

	////////////////////////////////////////////////////////////////////////
	// register indexes; byte address is four times the index
	localparam logic [7:0] ACR_IDX_INPUT_SETUP = 8'h46;
	localparam logic [7:0] ACR_IDX_GAIN = 8'h47;
	localparam logic [7:0] ACR_IDX_VOLUME = 8'h48;
	localparam logic [7:0] ACR_IDX_TRIM = 8'h49;
	localparam logic [7:0] ACR_IDX_STATUS = 8'h50;

	// reset values
	localparam logic [7:0] ACR_RST_INPUT_SETUP = 8'h10;
	localparam logic [7:0] ACR_RST_GAIN = 8'h00;
	localparam logic [7:0] ACR_RST_VOLUME = 8'hc9;
	localparam logic [7:0] ACR_RST_TRIM = 8'h80;

	// writable bit masks; zero bits are read-only and read as zero
	localparam logic [7:0] ACR_WMASK_INPUT_SETUP = 8'hff;
	localparam logic [7:0] ACR_WMASK_GAIN = 8'hfe;
	localparam logic [7:0] ACR_WMASK_VOLUME = 8'hff;
	localparam logic [7:0] ACR_WMASK_TRIM = 8'hf0;

	// field positions in the input setup register
	localparam int ACR_POS_KIND = 7;
	localparam int ACR_POS_SRC_HI = 6;
	localparam int ACR_POS_SRC_LO = 5;
	localparam int ACR_POS_COUPLING = 4;
	localparam int ACR_POS_SWING = 3;
	localparam int ACR_POS_PERF_HI = 2;
	localparam int ACR_POS_PERF_LO = 1;
	localparam int ACR_POS_AGC = 0;
	// field positions in gain and trim registers
	localparam int ACR_POS_GAIN_HI = 7;
	localparam int ACR_POS_GAIN_LO = 2;
	localparam int ACR_POS_TRIM_HI = 7;
	localparam int ACR_POS_TRIM_LO = 4;

	// field codes
	localparam logic [1:0] ACR_SRC_DIFF = 2'h0;
	localparam logic [1:0] ACR_SRC_SINGLE = 2'h1;
	localparam logic [1:0] ACR_PERF_SNR = 2'h0;
	localparam logic [1:0] ACR_PERF_FORBIDDEN = 2'h1;
	localparam logic [1:0] ACR_PERF_CMRR = 2'h2;
	localparam logic [5:0] ACR_GAIN_MAX = 6'h2a;
	localparam logic [7:0] ACR_VOL_MUTE = 8'h00;
	localparam logic [8:0] ACR_VOL_ZERO_DB = 9'h0c9;
	localparam logic [4:0] ACR_TRIM_ZERO_DB = 5'h08;

	// status register bit positions
	localparam int ACR_ST_SRC_RSVD = 0;
	localparam int ACR_ST_PERF_BAD = 1;
	localparam int ACR_ST_GAIN_RSVD = 2;
	localparam int ACR_ST_AGC_ON_DC = 3;
	localparam int ACR_ST_RETUNE = 4;
	localparam int ACR_ST_MUTED = 5;

	// apb request as seen by the slave
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} acr_apb_req_type;

	// apb answer
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} acr_apb_rsp_type;

	// decoded channel settings toward the analog front end
	typedef struct packed {
		logic input_kind_select;
		logic [1:0] input_source_select;
		logic coupling_select;
		logic mic_swing_range;
		logic [1:0] amplifier_perf_mode;
		logic auto_gain_enable;
		logic [5:0] analog_gain_code;
		logic [7:0] digital_volume_code;
		logic [3:0] gain_trim_code;
	} acr_setup_type;

	// byte address of a register index
	function automatic logic [11:0] acr_byte_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

endpackage

// file: sim/acr_regs_chk.sv
// checker for the channel 3 config bank, bound to the top module
// assumes one clock and synchronous active-high reset on its ports
`timescale 1ns/10ps

module acr_regs_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire acr_pkg::acr_apb_req_type apb_req_in,
	input wire logic agc_setup_mode_in,
	input wire acr_pkg::acr_apb_rsp_type apb_rsp_out,
	input wire acr_pkg::acr_setup_type setup_out,
	input wire logic agc_run_out,
	input wire logic channel_mute_out,
	input wire logic [8:0] volume_half_db_out,
	input wire logic [4:0] trim_tenth_db_out
);
	import acr_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// low byte of write data, kept apart so $past sees a plain signal
	logic [7:0] wbyte;
	assign wbyte = apb_req_in.pwdata[7:0];

	////////////////////////////////////////////////////////////////////////
	// bus steps
	sequence setup_phase;
		apb_req_in.psel && !apb_req_in.penable;
	endsequence
	sequence one_wait;
		!apb_rsp_out.pready ##1 apb_rsp_out.pready;
	endsequence
	sequence wr_done(logic [11:0] a);
		apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready &&
			apb_req_in.pwrite && apb_req_in.paddr == a;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// outputs settle one edge after the store, so check two edges later
	wait_state_a: assert property (setup_phase ##1
		apb_req_in.penable |-> one_wait)
		else $error("access phase length wrong");
	setup_store_a: assert property (
		wr_done(12'h118) |-> ##2
		{setup_out.input_kind_select, setup_out.input_source_select,
		setup_out.coupling_select, setup_out.mic_swing_range,
		setup_out.amplifier_perf_mode, setup_out.auto_gain_enable}
		== $past(wbyte, 2))
		else $error("setup fields differ from write");
	gain_store_a: assert property (wr_done(12'h11c) |-> ##2
		{setup_out.analog_gain_code, 2'h0} == ($past(wbyte, 2) & 8'hfc))
		else $error("gain code differs from write");
	vol_store_a: assert property (wr_done(12'h120) |-> ##2
		setup_out.digital_volume_code == $past(wbyte, 2))
		else $error("volume code differs from write");
	trim_store_a: assert property (wr_done(12'h124) |-> ##2
		{setup_out.gain_trim_code, 4'h0} == ($past(wbyte, 2) & 8'hf0))
		else $error("trim code differs from write");
	reset_val_a: assert property ($fell(rst_in) |=>
		setup_out == {8'h10, 6'h00, 8'hc9, 4'h8})
		else $error("settings not at reset values");
	mute_lvl_a: assert property (!$past(rst_in) |->
		channel_mute_out == (setup_out.digital_volume_code == 8'h00))
		else $error("mute does not follow volume code");
	vol_lvl_a: assert property (!$past(rst_in) && !channel_mute_out |->
		volume_half_db_out == {1'b0, setup_out.digital_volume_code} - 9'h0c9)
		else $error("volume level wrong");
	trim_lvl_a: assert property (!$past(rst_in) |->
		trim_tenth_db_out == {1'b0, setup_out.gain_trim_code} - 5'h08)
		else $error("trim level wrong");
	agc_run_a: assert property (!$past(rst_in) |-> agc_run_out ==
		(setup_out.auto_gain_enable && $past(agc_setup_mode_in)))
		else $error("agc run differs from enable and mode");
endmodule // acr_regs_chk

bind acr_regs acr_regs_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.apb_req_in(apb_req_in), .agc_setup_mode_in(agc_setup_mode_in),
	.apb_rsp_out(apb_rsp_out), .setup_out(setup_out),
	.agc_run_out(agc_run_out), .channel_mute_out(channel_mute_out),
	.volume_half_db_out(volume_half_db_out),
	.trim_tenth_db_out(trim_tenth_db_out));

// file: sim/tb_top.sv
// self-checking bench for the channel 3 config bank over apb
// assumes the checker is bound from its own file
`timescale 1ns/10ps

module tb_top;
	import acr_pkg::*;
	localparam logic [11:0] A_SET = {2'h0, ACR_IDX_INPUT_SETUP, 2'h0};
	localparam logic [11:0] A_GAIN = {2'h0, ACR_IDX_GAIN, 2'h0};
	localparam logic [11:0] A_VOL = {2'h0, ACR_IDX_VOLUME, 2'h0};
	localparam logic [11:0] A_TRIM = {2'h0, ACR_IDX_TRIM, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, ACR_IDX_STATUS, 2'h0};
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic agc_mode = 1'b0;
	acr_apb_req_type req = '0;
	acr_apb_rsp_type rsp;
	acr_setup_type setup;
	logic agc_run;
	logic mute;
	logic [8:0] vol_db;
	logic [4:0] trim_db;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	// write, then expected readback; reserved codes are kept as written
	// gain writes keep bits 1-0 zero; agc only set with ac coupling
	logic [11:0] ta [10] = '{A_SET, A_SET, A_SET, A_GAIN, A_GAIN, A_GAIN,
		A_VOL, A_VOL, A_TRIM, A_TRIM};
	logic [7:0] tw [10] = '{8'hef, 8'h24, 8'h4a, 8'ha8, 8'h54, 8'hfc,
		8'h00, 8'h01, 8'hff, 8'h0f};
	logic [7:0] te [10] = '{8'hef, 8'h24, 8'h4a, 8'ha8, 8'h54, 8'hfc,
		8'h00, 8'h01, 8'hf0, 8'h00};
	// volume codes and expected {mute, half-db level}
	logic [7:0] vc [4] = '{8'h00, 8'h01, 8'hff, 8'hc9};
	logic [9:0] lv [4] = '{10'h200, 10'h138, 10'h036, 10'h000};

	acr_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .apb_req_in(req),
		.agc_setup_mode_in(agc_mode), .apb_rsp_out(rsp), .setup_out(setup),
		.agc_run_out(agc_run), .channel_mute_out(mute),
		.volume_half_db_out(vol_db), .trim_tenth_db_out(trim_db));

	////////////////////////////////////////////////////////////////////////
	// clock and hang guard; whole run needs well under 2000 cycles
	always #4 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			$display("mismatch at %0t: timeout", $time);
			end_sim();
		end
	end

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// apb master: request held until pready is seen at a rising edge
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [7:0] d, output logic [31:0] rdat, output logic err);
		@(posedge clk_in);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= {24'ha5a5a5, d}; // upper bits must be ignored
		@(posedge clk_in);
		req.penable <= 1'b1;
		do @(posedge clk_in); while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input logic ee);
		logic [31:0] v;
		logic err;
		xfer(a, 1'b0, 8'h00, v, err);
		chk({31'h0, err}, {31'h0, ee}, "read error flag");
		chk(v, {24'h0, e}, "read data");
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic ee);
		logic [31:0] v;
		logic err;
		xfer(a, 1'b1, d, v, err);
		chk({31'h0, err}, {31'h0, ee}, "write error flag");
	endtask

	task automatic do_reset();
		rst_in <= 1'b1;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask

	task automatic reset_vals();
		rd(A_SET, 8'h10, 1'b0);
		rd(A_GAIN, 8'h00, 1'b0);
		rd(A_VOL, 8'hc9, 1'b0);
		rd(A_TRIM, 8'h80, 1'b0);
		rd(A_STAT, 8'h00, 1'b0);
		chk({24'h0, setup.digital_volume_code}, 32'hc9, "volume port");
		$display("test reset values done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		do_reset();
		reset_vals();
		for (int i = 0; i < 10; i++) begin
			wr(ta[i], tw[i], 1'b0);
			rd(ta[i], te[i], 1'b0);
		end
		$display("test write and read back done");
		// reserved source, forbidden perf code and gain 63 are flagged
		rd(A_STAT, 8'h07, 1'b0);
		wr(A_SET, 8'h08, 1'b0);
		rd(A_STAT, 8'h14, 1'b0);
		wr(A_VOL, 8'h00, 1'b0);
		rd(A_STAT, 8'h24, 1'b0);
		$display("test status done");
		for (int i = 0; i < 4; i++) begin
			wr(A_VOL, vc[i], 1'b0);
			repeat (3) @(posedge clk_in);
			chk({22'h0, mute, vol_db}, {22'h0, lv[i]}, "volume level");
		end
		wr(A_TRIM, 8'h00, 1'b0);
		repeat (3) @(posedge clk_in);
		chk({27'h0, trim_db}, 32'h18, "trim level");
		wr(A_TRIM, 8'hf0, 1'b0);
		repeat (3) @(posedge clk_in);
		chk({27'h0, trim_db}, 32'h07, "trim level");
		$display("test levels done");
		rd(12'h200, 8'h00, 1'b1);
		rd(12'h11d, 8'h00, 1'b1);
		wr(12'h200, 8'hff, 1'b1);
		$display("test unmapped done");
		wr(A_SET, 8'h01, 1'b0);
		agc_mode <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk({31'h0, agc_run}, 32'h1, "agc run");
		agc_mode <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk({31'h0, agc_run}, 32'h0, "agc run");
		$display("test agc done");
		do_reset();
		reset_vals();
		end_sim();
	end
endmodule // tb_top
